// ===== rtl/pdw_ctrl.sv
// power-down entry, wake-up detection and restart delay
`timescale 1ns/100ps
`include "pdw_params.svh"
module pdw_ctrl (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // core
  input  wire logic        halt_exec,
  input  wire logic        clr_wdt_exec,
  input  wire logic        stack_full,
  output logic             core_stall_o,
  output logic             resume_o,
  output logic             irq_entry_o,
  output logic             full_rst_o,
  output logic             pc_sp_rst_o,
  // wake sources
  input  wire logic        ext_rst_n_pin,
  input  wire logic [7:0]  port_pin,
  input  wire logic [3:0]  irq_req,
  input  wire logic [3:0]  irq_en,
  input  wire logic        wdt_ovf,
  // clocks and watchdog
  output logic             sys_osc_en_o,
  output logic             core_freq_select,
  output logic             freeze_o,
  output logic             wdt_clr_o,
  output logic             wdt_run_o,
  output logic             wdt_osc_en_o,
  // flags
  output logic             power_down_flag,
  output logic             watchdog_expired_flag
);

  localparam logic [9:0] TERM_CNT = 10'(`PDW_RESTART_CYC - 1);

  pdw_pkg::pdw_state_t st_r;
  pdw_pkg::pdw_cause_t cause_r;
  pdw_pkg::pdw_ctrl_t  ctrl_r;
  logic [9:0]          cnt_r;
  logic [3:0]          stale_r;
  logic [3:0]          wirq_r;
  logic                ack_r;
  logic [31:0]         dat_r;
  logic                ext_s1_r;
  logic                ext_s2_r;
  logic                ext_d_r;
  logic [7:0]          pin_s1_r;
  logic [7:0]          pin_s2_r;
  logic [7:0]          pin_d_r;
  logic                pdf_r;
  logic                to_r;
  logic                resume_r;
  logic                irq_entry_r;
  logic                full_rst_r;
  logic                pc_sp_rst_r;
  logic                wdt_clr_r;

  logic                ext_go;
  logic [7:0]          pin_fall;
  logic [3:0]          irq_fresh;
  logic                wdt_go;
  logic                term;
  logic                take_irq;
  logic                halt_go;
  logic                bus_hit;

  // byte-lane merge for the control register
  function automatic logic [10:0] lane_merge(input logic [10:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  sel);
    logic [10:0] v;
    v = old;
    if (sel[0])
    begin
      v[7:0] = d[7:0];
    end
    if (sel[1])
    begin
      v[10:8] = d[10:8];
    end
    return v;
  endfunction : lane_merge

  // read data for a byte address; unmapped reads as zero
  function automatic logic [31:0] rd_word(input logic [3:0] adr,
                                          input logic [10:0] c,
                                          input logic [7:0] s);
    if (adr == `PDW_ADR_CTRL)
    begin
      return {21'h000000, c};
    end
    else if (adr == `PDW_ADR_STAT)
    begin
      return {24'h000000, s};
    end
    else
    begin
      return 32'h00000000;
    end
  endfunction : rd_word

  // async pins pass two flops before any logic reads them
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_d_r  <= 1'b1;
      pin_s1_r <= `PDW_PIN_IDLE;
      pin_s2_r <= `PDW_PIN_IDLE;
      pin_d_r  <= `PDW_PIN_IDLE;
    end
    else if (clk_en)
    begin
      ext_s1_r <= ext_rst_n_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
      pin_s1_r <= port_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  assign ext_go    = ext_d_r & ~ext_s2_r;
  assign pin_fall  = pin_d_r & ~pin_s2_r & ctrl_r.wake_en; // RL10
  assign irq_fresh = irq_req & ~stale_r; // RL14
  assign wdt_go    = wdt_ovf & wdt_run_o;
  assign term      = (cnt_r == TERM_CNT);
  assign take_irq  = |(wirq_r & irq_en) & ~stack_full; // RL13
  assign halt_go   = (st_r == pdw_pkg::PDW_RUN) & halt_exec; // RL1
  assign bus_hit   = wb_cyc_i & wb_stb_i & ~ack_r;

  // sequencer: run, halted, restart delay, interrupt wait
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r    <= pdw_pkg::PDW_RUN;
      cause_r <= pdw_pkg::PDW_C_NONE;
      cnt_r   <= 10'h000;
      stale_r <= 4'h0;
      wirq_r  <= 4'h0;
    end
    else if (clk_en)
    begin
      case (st_r)
        pdw_pkg::PDW_RUN:
        begin
          if (halt_go)
          begin
            st_r    <= pdw_pkg::PDW_HALT; // RL1
            stale_r <= irq_req; // RL14
          end
        end
        pdw_pkg::PDW_HALT:
        begin
          cnt_r <= 10'h000;
          if (ext_go)
          begin
            st_r    <= pdw_pkg::PDW_DELAY; // RL6
            cause_r <= pdw_pkg::PDW_C_EXT;
          end
          else if (wdt_go)
          begin
            st_r    <= pdw_pkg::PDW_DELAY; // RL6
            cause_r <= pdw_pkg::PDW_C_WDT;
          end
          else if (|pin_fall)
          begin
            st_r    <= pdw_pkg::PDW_DELAY; // RL6
            cause_r <= pdw_pkg::PDW_C_PIN;
          end
          else if (|irq_fresh)
          begin
            st_r    <= pdw_pkg::PDW_DELAY; // RL6
            cause_r <= pdw_pkg::PDW_C_IRQ;
            wirq_r  <= irq_fresh;
          end
        end
        pdw_pkg::PDW_DELAY:
        begin
          // counts on the restarted oscillator; core stays stalled
          if (term) // RL21
          begin
            if (cause_r == pdw_pkg::PDW_C_IRQ && take_irq)
            begin
              st_r <= pdw_pkg::PDW_IRQW; // RL16
            end
            else
            begin
              st_r <= pdw_pkg::PDW_RUN; // RL17
            end
          end
          else
          begin
            cnt_r <= cnt_r + 10'h001; // RL15
          end
        end
        pdw_pkg::PDW_IRQW:
        begin
          st_r <= pdw_pkg::PDW_RUN;
        end
        default:
        begin
          st_r <= pdw_pkg::PDW_RUN;
        end
      endcase
    end
  end

  // one-cycle actions toward the core and watchdog
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resume_r    <= 1'b0;
      irq_entry_r <= 1'b0;
      full_rst_r  <= 1'b0;
      pc_sp_rst_r <= 1'b0;
      wdt_clr_r   <= 1'b0;
    end
    else if (clk_en)
    begin
      // interrupt request flag is left pending, not cleared here
      resume_r    <= (st_r == pdw_pkg::PDW_DELAY) & term &
                     ((cause_r == pdw_pkg::PDW_C_PIN) |
                      ((cause_r == pdw_pkg::PDW_C_IRQ) & ~take_irq)); // RL11 RL12
      irq_entry_r <= (st_r == pdw_pkg::PDW_IRQW); // RL13
      full_rst_r  <= ((st_r == pdw_pkg::PDW_RUN) & (ext_go | wdt_go)) |
                     ((st_r == pdw_pkg::PDW_DELAY) & term &
                      (cause_r == pdw_pkg::PDW_C_EXT)); // RL7
      pc_sp_rst_r <= (st_r == pdw_pkg::PDW_DELAY) & term &
                     (cause_r == pdw_pkg::PDW_C_WDT); // RL8
      wdt_clr_r   <= halt_go; // RL4
    end
  end

  // status flags; a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pdf_r <= 1'b0; // RL9
      to_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (halt_go)
      begin
        pdf_r <= 1'b1; // RL5
      end
      else if (clr_wdt_exec | ext_go)
      begin
        pdf_r <= 1'b0; // RL9
      end
      if (wdt_go)
      begin
        to_r <= 1'b1; // RL8 RL20
      end
      else if (halt_go | ext_go)
      begin
        to_r <= 1'b0; // RL5
      end
    end
  end

  // wishbone slave: one wait cycle, ack drops the cycle after
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ack_r  <= 1'b0;
      dat_r  <= 32'h00000000;
      ctrl_r <= `PDW_CTRL_RST;
    end
    else if (clk_en)
    begin
      ack_r <= bus_hit;
      if (bus_hit)
      begin
        dat_r <= rd_word(wb_adr_i, ctrl_r,
                         {cause_r, st_r, to_r, pdf_r});
      end
      // write lands on the edge where the master samples ack, not before
      if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_adr_i == `PDW_ADR_CTRL)
      begin
        ctrl_r <= lane_merge(ctrl_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  assign wb_ack_o              = ack_r;
  assign wb_dat_o              = dat_r;
  assign core_stall_o          = (st_r != pdw_pkg::PDW_RUN); // RL2 RL21
  assign sys_osc_en_o          = (st_r != pdw_pkg::PDW_HALT); // RL2
  assign freeze_o              = (st_r == pdw_pkg::PDW_HALT); // RL3
  assign wdt_run_o             = (st_r != pdw_pkg::PDW_HALT) |
                                 (ctrl_r.rc_sel & ~ctrl_r.osc_off); // RL4
  assign wdt_osc_en_o          = ~ctrl_r.osc_off; // RL19
  assign core_freq_select      = ctrl_r.freq; // RL18
  assign resume_o              = resume_r;
  assign irq_entry_o           = irq_entry_r;
  assign full_rst_o            = full_rst_r;
  assign pc_sp_rst_o           = pc_sp_rst_r;
  assign wdt_clr_o             = wdt_clr_r;
  assign power_down_flag       = pdf_r;
  assign watchdog_expired_flag = to_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_delay_end;
    clk_en && st_r == pdw_pkg::PDW_DELAY && term;
  endsequence

  halt_entry_a: assert property ( // RL1
    $rose(st_r == pdw_pkg::PDW_HALT) |-> $past(halt_exec))
    else $error("halt state entered without halt");
  osc_stop_a: assert property ( // RL2
    st_r == pdw_pkg::PDW_HALT |-> !sys_osc_en_o && core_stall_o && freeze_o)
    else $error("oscillator not stopped in halt");
  wdt_stop_a: assert property ( // RL4
    st_r == pdw_pkg::PDW_HALT && !ctrl_r.rc_sel |-> !wdt_run_o)
    else $error("watchdog runs on stopped clock");
  halt_flags_a: assert property ( // RL5
    clk_en && halt_go && !wdt_go |=> pdf_r && !to_r && wdt_clr_o)
    else $error("halt did not update flags");
  stale_irq_a: assert property ( // RL14
    clk_en && st_r == pdw_pkg::PDW_HALT && !ext_go && !wdt_go && pin_fall == 8'h00
    && irq_fresh == 4'h0 |=> st_r == pdw_pkg::PDW_HALT)
    else $error("stale interrupt woke device");
  delay_len_a: assert property ( // RL15
    $fell(st_r == pdw_pkg::PDW_DELAY) |-> $past(cnt_r) == TERM_CNT)
    else $error("restart delay length wrong");
  irq_late_a: assert property ( // RL16
    s_delay_end ##0 (cause_r == pdw_pkg::PDW_C_IRQ && take_irq)
    |=> core_stall_o ##1 irq_entry_o)
    else $error("interrupt entry not one cycle late");
  resume_now_a: assert property ( // RL17
    s_delay_end ##0 cause_r == pdw_pkg::PDW_C_PIN |=> resume_o && !core_stall_o)
    else $error("resume not right after delay");
  wdt_wake_a: assert property ( // RL8
    s_delay_end ##0 cause_r == pdw_pkg::PDW_C_WDT |=> pc_sp_rst_o && !full_rst_o)
    else $error("watchdog wake reset wrong");
  ext_wake_a: assert property ( // RL7
    s_delay_end ##0 cause_r == pdw_pkg::PDW_C_EXT |=> full_rst_o && !resume_o)
    else $error("reset wake did not reset fully");
  masked_irq_a: assert property ( // RL12
    s_delay_end ##0 (cause_r == pdw_pkg::PDW_C_IRQ && !take_irq) |=> resume_o && !core_stall_o)
    else $error("masked interrupt did not resume");
  clr_pdf_a: assert property ( // RL9
    clk_en && clr_wdt_exec && !halt_go |=> !pdf_r)
    else $error("clear-watchdog left power-down flag");
  run_expiry_a: assert property ( // RL20
    clk_en && st_r == pdw_pkg::PDW_RUN && wdt_go && !halt_go && !clr_wdt_exec && !ext_go
    |=> to_r && pdf_r == $past(pdf_r))
    else $error("running expiry changed flags wrong");
  wake_start_a: assert property ( // RL6
    clk_en && st_r == pdw_pkg::PDW_HALT && (ext_go || wdt_go || pin_fall != 8'h00)
    |=> st_r == pdw_pkg::PDW_DELAY)
    else $error("wake event did not start delay");
endmodule : pdw_ctrl

// ===== rtl/pdw_params.svh
// constants for power-down and wake-up control
// Operation
// RL1: only the halt instruction enters power-down
// RL2: halt stops oscillator, holds execution at halt
// RL3: memory, registers and ports kept while down
// RL4: halt clears watchdog; runs only on own oscillator
// RL5: halt sets power-down flag, clears expired flag
// RL6: wake on reset, pin fall, interrupt, watchdog
// RL7: external reset wake gives full system reset
// RL8: watchdog wake sets expired, resets pc, sp
// RL9: power-down flag cleared by power-up, clear-watchdog
// RL10: each port pin has its own wake enable
// RL11: pin wake resumes after halt, no reset
// RL12: masked or stack-full interrupt resumes, stays pending
// RL13: enabled interrupt with stack room takes entry
// RL14: interrupt pending before halt cannot wake
// RL15: wait 1024 system clocks after any wake
// RL16: interrupt entry one cycle after the delay
// RL17: next instruction runs right after the delay
// RL18: frequency select bit chooses core clock rate
// RL19: watchdog oscillator runs while down unless disabled
// RL20: normal watchdog expiry sets flag, keeps power-down
// RL21: restart counter stalls core until terminal count
`ifndef PDW_PARAMS_SVH
`define PDW_PARAMS_SVH
`define PDW_ADR_CTRL        4'h0
`define PDW_ADR_STAT        4'h4
`define PDW_CTRL_RST        11'h000
`define PDW_WAKE_EN_LSB     0
`define PDW_FREQ_BIT        8
`define PDW_RC_SEL_BIT      9
`define PDW_OSC_OFF_BIT     10
`define PDW_STAT_PDF_BIT    0
`define PDW_STAT_TO_BIT     1
`define PDW_STAT_ST_LSB     2
`define PDW_STAT_CAUSE_LSB  5
`define PDW_RESTART_PERIODS 1024
`define PDW_RESTART_CYC     (`PDW_RESTART_PERIODS * 1)
`define PDW_PIN_IDLE        8'hFF
`endif

// ===== rtl/pdw_pkg.sv
// types for power-down and wake-up control
package pdw_pkg;
  typedef enum logic [2:0] {
    PDW_RUN   = 3'h0,
    PDW_HALT  = 3'h1,
    PDW_DELAY = 3'h2,
    PDW_IRQW  = 3'h3
  } pdw_state_t;

  typedef enum logic [2:0] {
    PDW_C_NONE = 3'h0,
    PDW_C_EXT  = 3'h1,
    PDW_C_WDT  = 3'h2,
    PDW_C_PIN  = 3'h3,
    PDW_C_IRQ  = 3'h4
  } pdw_cause_t;

  typedef struct packed {
    logic       osc_off;
    logic       rc_sel;
    logic       freq;
    logic [7:0] wake_en;
  } pdw_ctrl_t;
endpackage : pdw_pkg

// ===== tb/pdw_core_model.sv
// core and wake pin model facing the power-down controller
`timescale 1ns/100ps
module pdw_core_model (
  // clock
  input  wire logic       ref_clk,
  // bench controls
  input  wire logic [7:0] pin_low,
  input  wire logic       ext_low,
  // to the controller
  output logic            halt_exec,
  output logic [7:0]      port_pin,
  output logic            ext_rst_n_pin
);
  // pins have pull-ups, so a released pin reads high
  assign port_pin      = ~pin_low;
  assign ext_rst_n_pin = ~ext_low;

  initial halt_exec = 1'b0;

  // halt lasts one instruction cycle, launched right after an edge
  task automatic do_halt;
    halt_exec <= 1'b1;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
  endtask : do_halt
endmodule : pdw_core_model

// ===== tb/testbench.sv
// self-checking bench for the power-down and wake-up controller
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [10:0] ctrl;
    logic [2:0]  cause;
    logic        ien;
    logic        sfull;
    logic [3:0]  pulse;
    logic [10:0] lo;
    logic [10:0] hi;
    logic [1:0]  flags;
  } pdw_row_t;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        halt_exec;
  logic        clr_wdt_exec = 1'b0;
  logic        stack_full = 1'b0;
  logic        core_stall_o, resume_o, irq_entry_o, full_rst_o, pc_sp_rst_o;
  logic        ext_rst_n_pin;
  logic [7:0]  port_pin;
  logic [3:0]  irq_req = 4'h0;
  logic [3:0]  irq_en = 4'h0;
  logic        wdt_ovf = 1'b0;
  logic        sys_osc_en_o, core_freq_select, freeze_o;
  logic        wdt_clr_o, wdt_run_o, wdt_osc_en_o;
  logic        power_down_flag, watchdog_expired_flag;
  logic [7:0]  pin_low = 8'h00;
  logic        ext_low = 1'b0;
  logic [31:0] q;
  logic [3:0]  pv;
  int          n;
  int          mismatches = 0;
  int          compares = 0;
  pdw_row_t    r;
  // causes: 1 ext, 2 wdt, 3 pin, 4 irq; pulses {resume, entry, full, pc_sp}
  pdw_row_t    rows [6] = '{
    '{11'h101, 3'h3, 1'b0, 1'b0, 4'h8, 11'h403, 11'h407, 2'h1},
    '{11'h200, 3'h2, 1'b0, 1'b0, 4'h1, 11'h402, 11'h402, 2'h3},
    '{11'h000, 3'h4, 1'b1, 1'b0, 4'h4, 11'h403, 11'h403, 2'h1},
    '{11'h100, 3'h4, 1'b0, 1'b0, 4'h8, 11'h402, 11'h402, 2'h1},
    '{11'h000, 3'h4, 1'b1, 1'b1, 4'h8, 11'h402, 11'h402, 2'h1},
    '{11'h000, 3'h1, 1'b0, 1'b0, 4'h2, 11'h403, 11'h407, 2'h0}};

  always #25 ref_clk = ~ref_clk;

  pdw_ctrl pdw_ctrl_inst (.ref_clk, .rst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .halt_exec, .clr_wdt_exec,
    .stack_full, .core_stall_o, .resume_o, .irq_entry_o, .full_rst_o, .pc_sp_rst_o,
    .ext_rst_n_pin, .port_pin, .irq_req, .irq_en, .wdt_ovf, .sys_osc_en_o,
    .core_freq_select, .freeze_o, .wdt_clr_o, .wdt_run_o, .wdt_osc_en_o,
    .power_down_flag, .watchdog_expired_flag);

  pdw_core_model pdw_core_model_inst (.ref_clk, .pin_low, .ext_low, .halt_exec,
    .port_pin, .ext_rst_n_pin);

  task automatic end_sim;
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      mismatches++;
      end_sim;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  // counts edges until a restart pulse; a lost wake must not hang the run
  task automatic wait_pulse(output int c, output logic [3:0] p);
    c = 0;
    p = 4'h0;
    while (p === 4'h0 && c < 1100)
    begin
      @(posedge ref_clk);
      c++;
      if (c == 1)
        wdt_ovf <= 1'b0;
      p = {resume_o, irq_entry_o, full_rst_o, pc_sp_rst_o};
    end
    if (c >= 1100)
    begin
      mismatches++;
      end_sim;
    end
  endtask : wait_pulse

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({sys_osc_en_o, core_stall_o, wdt_run_o, wdt_osc_en_o, core_freq_select,
         power_down_flag, watchdog_expired_flag}, 7'h58);
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0);
    foreach (rows[i])
    begin
      r = rows[i];
      wb(1'b1, 4'h0, {21'h0, r.ctrl}, q);
      chk(core_freq_select, r.ctrl[8]);
      irq_en     <= {2'h0, r.ien, 1'b0};
      stack_full <= r.sfull;
      pdw_core_model_inst.do_halt();
      @(posedge ref_clk);
      chk({sys_osc_en_o, freeze_o, wdt_clr_o, power_down_flag, watchdog_expired_flag,
           core_stall_o}, 6'h1D);
      chk(wdt_run_o, r.ctrl[9] & ~r.ctrl[10]);
      case (r.cause)
        3'h1: ext_low <= 1'b1;
        3'h2: wdt_ovf <= 1'b1;
        3'h3: pin_low <= 8'h01;
        default: irq_req <= 4'h2;
      endcase
      wait_pulse(n, pv);
      chk(pv, r.pulse);
      chk(n >= r.lo && n <= r.hi, 1'b1);
      chk(core_stall_o, 1'b0);
      pin_low <= 8'h00;
      ext_low <= 1'b0;
      irq_req <= 4'h0;
      wb(1'b0, 4'h4, 32'h0, q);
      chk(q[7:0], {r.cause, 3'h0, r.flags});
    end
    // stale request, watchdog on system clock, and a disabled pin must not wake
    wb(1'b1, 4'h0, 32'h1, q);
    irq_req <= 4'h1;
    irq_en  <= 4'h1;
    stack_full <= 1'b0;
    pdw_core_model_inst.do_halt();
    @(posedge ref_clk);
    chk(wdt_run_o, 1'b0);
    wdt_ovf <= 1'b1;
    pin_low <= 8'h02;
    @(posedge ref_clk);
    wdt_ovf <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(core_stall_o, 1'b1);
    pin_low <= 8'h03;
    wait_pulse(n, pv);
    chk(pv, 4'h8);
    irq_req <= 4'h0;
    pin_low <= 8'h00;
    // watchdog expiry while running keeps the power-down flag
    wdt_ovf <= 1'b1;
    @(posedge ref_clk);
    wdt_ovf <= 1'b0;
    @(posedge ref_clk);
    chk(full_rst_o, 1'b1);
    wb(1'b0, 4'h4, 32'h0, q);
    chk(q[1:0], 2'h3);
    clr_wdt_exec <= 1'b1;
    @(posedge ref_clk);
    clr_wdt_exec <= 1'b0;
    @(posedge ref_clk);
    chk({watchdog_expired_flag, power_down_flag}, 2'h2);
    // register writes never stall the core; odd places are inert
    wb(1'b1, 4'h4, 32'hFFFF_FFFF, q);
    wb(1'b1, 4'h8, 32'hFFFF_FFFF, q);
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, 4'h4, 32'h0, q);
    chk({q[4:0], core_stall_o}, 6'h04);
    wb(1'b1, 4'h0, 32'hFFFF_FFFF, q);
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h7FF);
    chk({wdt_osc_en_o, core_freq_select}, 2'h1);
    // a low enable freezes everything, so this halt is never taken
    clk_en <= 1'b0;
    pdw_core_model_inst.do_halt();
    @(posedge ref_clk);
    clk_en <= 1'b1;
    chk({core_stall_o, power_down_flag}, 2'h0);
    // reset in mid-run returns flags and control to idle
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({sys_osc_en_o, core_stall_o, wdt_run_o, wdt_osc_en_o, core_freq_select,
         power_down_flag, watchdog_expired_flag}, 7'h58);
    end_sim;
  end
endmodule : testbench
